//--- hdl/frcc_defines.svh
// frcc_defines.svh: offsets, field positions, codes and reset values
// assumes: included by the top module only, no other use
`ifndef FRCC_DEFINES_SVH
`define FRCC_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------
`define FRCC_OFS_CTRL     8'h00
`define FRCC_OFS_FLAG     8'h04
`define FRCC_OFS_RB_LO    8'h08
`define FRCC_OFS_RB_HI    8'h0c
`define FRCC_OFS_ADDR     8'h10

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FRCC_CTRL_SRST    0
`define FRCC_CTRL_DEV_LO  1
`define FRCC_CTRL_SEC_LO  16
`define FRCC_FLAG_RANGE   1
`define FRCC_FLAG_SUSP    2
`define FRCC_FLAG_CRC     4
`define FRCC_FLAG_READY   7

// ---------------------------------------------------------------
// link codes, crc constants, reset values
// ---------------------------------------------------------------
`define FRCC_CODE_ACT     8'h9b
`define FRCC_CODE_SUB     8'h27
`define FRCC_CODE_RANGE   8'hfe
`define FRCC_CODE_RDBACK  8'h96
`define FRCC_CODE_SUSPEND 8'h75
`define FRCC_SEQ_BYTES    5'h13
`define FRCC_RB_BYTES     7'h08
`define FRCC_RB_LOCS      7'h40
`define FRCC_CRC_POLY     64'h42f0e1eba9ea3693
`define FRCC_CRC_INIT     64'h0000000000000000
`define FRCC_RB_RESET     64'h0000000000000000

`endif

//--- hdl/frcc_pkg.sv
// frcc_pkg.sv: types of the range crc check block
// assumes: nothing included; no macro of frcc_defines.svh used
package frcc_pkg;

  typedef enum logic [1:0] {
    FRCC_MODE_NONE, FRCC_MODE_SEQ, FRCC_MODE_RDBACK, FRCC_MODE_BAD
  } frcc_mode_type;

  typedef enum logic [1:0] {
    FRCC_ENG_IDLE, FRCC_ENG_REQ, FRCC_ENG_WAIT
  } frcc_eng_type;

  typedef enum logic [1:0] {
    FRCC_DEV_STANDBY, FRCC_DEV_PROG_ERASE, FRCC_DEV_SUB_PROG_SUSP,
    FRCC_DEV_ERASE_SUSP
  } frcc_dev_type;

  typedef enum logic [2:0] {
    FRCC_OP_READ_MEM, FRCC_OP_READ_STATUS, FRCC_OP_PROGRAM,
    FRCC_OP_ERASE, FRCC_OP_WRITE_NV, FRCC_OP_WRITE_VOL, FRCC_OP_SUSPEND
  } frcc_op_type;

  typedef struct packed {
    logic [2:0]    cs_s;
    logic [2:0]    sck_s;
    logic [1:0]    mosi_s;
    logic [2:0]    bit_cnt;
    logic [4:0]    byte_cnt;
    logic [6:0]    shift;
    frcc_mode_type mode;
    logic [2:0]    out_cnt;
    logic [7:0]    out_sh;
    logic [6:0]    rb_idx;
    logic          miso;
    logic          miso_oe;
    logic [63:0]   exp_crc;
    logic [31:0]   seq_start;
    logic [31:0]   seq_end;
    frcc_eng_type  eng;
    logic [63:0]   crc;
    logic [31:0]   addr;
    logic [31:0]   stop;
    logic [63:0]   rb;
    logic          flag_range;
    logic          flag_susp;
    logic          flag_crc;
    logic          mem_rd;
    logic [31:0]   mem_addr;
    frcc_dev_type  dev;
    logic [15:0]   susp_sector;
    logic          op_done;
    logic          op_accept;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic          crc_busy;
  } frcc_state_type;

endpackage

//--- hdl/frcc_top.sv
// frcc_top.sv: range crc check engine, serial link, admission, apb
// assumes: ref_clk 100 MHz; link pins asynchronous; memory on ref_clk
`include "frcc_defines.svh"

module frcc_top (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  output logic             mem_rd,
  output logic      [31:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rvalid,
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_class,
  input  wire logic [15:0] op_sector,
  output logic             op_done,
  output logic             op_accept,
  output logic             crc_busy
);

  frcc_pkg::frcc_state_type s_r;
  frcc_pkg::frcc_state_type s_nxt;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [63:0] crc_byte(input logic [63:0] c,
                                           input logic [7:0]  d);
    logic [63:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[63] ^ d[i];
      r  = {r[62:0], 1'b0} ^ (fb ? `FRCC_CRC_POLY : 64'h0);
    end
    return r;
  endfunction

  function automatic logic [7:0] rb_byte(input logic [63:0] rb,
                                         input logic [6:0]  idx);
    if (idx < `FRCC_RB_BYTES) begin
      return rb[idx[2:0]*8 +: 8];
    end
    return 8'h00;
  endfunction

  function automatic logic admit(input frcc_pkg::frcc_dev_type dev,
                                 input logic [2:0]  cls,
                                 input logic [15:0] sec,
                                 input logic [15:0] ssec);
    logic ok;
    ok = 1'b0;
    case (dev)
      frcc_pkg::FRCC_DEV_STANDBY:
        ok = (cls != frcc_pkg::FRCC_OP_SUSPEND);
      frcc_pkg::FRCC_DEV_PROG_ERASE:
        ok = (cls == frcc_pkg::FRCC_OP_READ_STATUS) ||
             (cls == frcc_pkg::FRCC_OP_SUSPEND);
      frcc_pkg::FRCC_DEV_SUB_PROG_SUSP:
        ok = (cls == frcc_pkg::FRCC_OP_READ_MEM) ||
             (cls == frcc_pkg::FRCC_OP_READ_STATUS) ||
             (cls == frcc_pkg::FRCC_OP_WRITE_VOL);
      frcc_pkg::FRCC_DEV_ERASE_SUSP:
        ok = (cls == frcc_pkg::FRCC_OP_READ_MEM) ||
             (cls == frcc_pkg::FRCC_OP_READ_STATUS) ||
             (cls == frcc_pkg::FRCC_OP_WRITE_VOL) ||
             ((cls == frcc_pkg::FRCC_OP_PROGRAM) && (sec != ssec));
      default: ok = 1'b0;
    endcase
    // erase and nonvolatile writes only in standby
    if ((cls == frcc_pkg::FRCC_OP_ERASE ||
         cls == frcc_pkg::FRCC_OP_WRITE_NV) &&
        dev != frcc_pkg::FRCC_DEV_STANDBY) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  logic       cs_low;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       byte_end;
  logic [7:0] rx_byte;
  logic       confirm;
  logic       bad_range;
  logic       apb_wr;
  logic       apb_rd;
  logic       soft_rst;
  logic       busy;
  logic       fold;
  logic       last;
  logic       susp_cmd;
  logic [63:0] crc_fold;

  always_comb begin
    cs_low    = ~s_r.cs_s[1];
    cs_rise   = s_r.cs_s[1] & ~s_r.cs_s[2];
    sck_rise  = s_r.sck_s[1] & ~s_r.sck_s[2] & cs_low;
    sck_fall  = ~s_r.sck_s[1] & s_r.sck_s[2] & cs_low;
    byte_end  = sck_rise && (s_r.bit_cnt == 3'h7);
    rx_byte   = {s_r.shift, s_r.mosi_s[1]};
    busy      = (s_r.eng != frcc_pkg::FRCC_ENG_IDLE);
    // whole sequence, byte aligned, then chip select high
    confirm   = cs_rise && (s_r.mode == frcc_pkg::FRCC_MODE_SEQ) &&
                (s_r.byte_cnt == `FRCC_SEQ_BYTES) &&
                (s_r.bit_cnt == 3'h0) && !busy;
    bad_range = s_r.seq_end < s_r.seq_start;
    apb_wr    = psel & penable & pwrite & ~s_r.pready;
    apb_rd    = psel & penable & ~pwrite & ~s_r.pready;
    soft_rst  = apb_wr && (paddr == `FRCC_OFS_CTRL) &&
                pwdata[`FRCC_CTRL_SRST];
    fold      = (s_r.eng == frcc_pkg::FRCC_ENG_WAIT) && mem_rvalid;
    last      = fold && (s_r.addr == s_r.stop);
    susp_cmd  = byte_end && (s_r.byte_cnt == 5'h0) &&
                (rx_byte == `FRCC_CODE_SUSPEND) && busy;
    crc_fold  = crc_byte(s_r.crc, mem_rdata);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_s    = {s_r.cs_s[1:0], cs_n};
    s_nxt.sck_s   = {s_r.sck_s[1:0], sck};
    s_nxt.mosi_s  = {s_r.mosi_s[0], mosi};
    s_nxt.mem_rd  = 1'b0;
    s_nxt.op_done = 1'b0;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;

    // link framing and byte capture
    if (!cs_low) begin
      s_nxt.bit_cnt  = 3'h0;
      s_nxt.byte_cnt = 5'h0;
      s_nxt.mode     = frcc_pkg::FRCC_MODE_NONE;
      s_nxt.miso_oe  = 1'b0;
    end else if (sck_rise) begin
      s_nxt.shift   = rx_byte[6:0];
      s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
      if (byte_end) begin
        if (s_r.byte_cnt != 5'h1f) begin
          s_nxt.byte_cnt = s_r.byte_cnt + 5'h1;
        end
        case (s_r.mode == frcc_pkg::FRCC_MODE_RDBACK ? 5'h1f : s_r.byte_cnt)
          5'h00: begin
            if (rx_byte == `FRCC_CODE_ACT) begin
              s_nxt.mode = frcc_pkg::FRCC_MODE_SEQ;
            end else if (rx_byte == `FRCC_CODE_RDBACK) begin
              s_nxt.mode    = frcc_pkg::FRCC_MODE_RDBACK;
              s_nxt.out_sh  = rb_byte(s_r.rb, 7'h0);
              s_nxt.rb_idx  = 7'h1;
              s_nxt.out_cnt = 3'h0;
              s_nxt.miso_oe = 1'b1;
            end else begin
              s_nxt.mode = frcc_pkg::FRCC_MODE_BAD;
            end
          end
          5'h01: begin
            if (rx_byte != `FRCC_CODE_SUB) begin
              s_nxt.mode = frcc_pkg::FRCC_MODE_BAD;
            end
          end
          5'h02: begin
            if (rx_byte != `FRCC_CODE_RANGE) begin
              s_nxt.mode = frcc_pkg::FRCC_MODE_BAD;
            end
          end
          default: begin
            if (s_r.mode == frcc_pkg::FRCC_MODE_SEQ && !busy) begin
              if (s_r.byte_cnt >= 5'h03 && s_r.byte_cnt <= 5'h0a) begin
                s_nxt.exp_crc[(s_r.byte_cnt - 5'h03)*8 +: 8] =
                  rx_byte;
              end else if (s_r.byte_cnt <= 5'h0e) begin
                s_nxt.seq_start[(s_r.byte_cnt - 5'h0b)*8 +: 8] =
                  rx_byte;
              end else if (s_r.byte_cnt <= 5'h12) begin
                s_nxt.seq_end[(s_r.byte_cnt - 5'h0f)*8 +: 8] =
                  rx_byte;
              end
            end
          end
        endcase
      end
    end else if (sck_fall && s_r.mode == frcc_pkg::FRCC_MODE_RDBACK) begin
      // readback shifts out msb of each byte first
      s_nxt.miso    = s_r.out_sh[7];
      s_nxt.out_cnt = s_r.out_cnt + 3'h1;
      if (s_r.out_cnt == 3'h7) begin
        s_nxt.out_sh = rb_byte(s_r.rb, s_r.rb_idx);
        if (s_r.rb_idx != 7'h7f) begin
          s_nxt.rb_idx = s_r.rb_idx + 7'h1;
        end
      end else begin
        s_nxt.out_sh = {s_r.out_sh[6:0], 1'b0};
      end
    end

    // suspend request while busy; the clear at the end of the check and the software reset win over the set
    if (susp_cmd) begin
      s_nxt.flag_susp = 1'b1;
    end

    // check engine; write enable latch is never consulted
    case (s_r.eng)
      frcc_pkg::FRCC_ENG_IDLE: begin
        if (confirm) begin
          s_nxt.rb = `FRCC_RB_RESET;
          if (bad_range) begin
            s_nxt.flag_range = 1'b1;
          end else begin
            s_nxt.crc  = `FRCC_CRC_INIT;
            s_nxt.addr = s_r.seq_start;
            s_nxt.stop = s_r.seq_end;
            s_nxt.eng  = frcc_pkg::FRCC_ENG_REQ;
          end
        end
      end
      frcc_pkg::FRCC_ENG_REQ: begin
        s_nxt.mem_rd   = 1'b1;
        s_nxt.mem_addr = s_r.addr;
        s_nxt.eng      = frcc_pkg::FRCC_ENG_WAIT;
      end
      frcc_pkg::FRCC_ENG_WAIT: begin
        if (fold) begin
          s_nxt.crc = crc_fold;
          if (last) begin
            s_nxt.eng       = frcc_pkg::FRCC_ENG_IDLE;
            s_nxt.flag_susp = 1'b0;
            if (crc_fold != s_r.exp_crc) begin
              s_nxt.flag_crc = 1'b1;
              s_nxt.rb       = crc_fold;
            end
          end else begin
            s_nxt.addr = s_r.addr + 32'h1;
            s_nxt.eng  = frcc_pkg::FRCC_ENG_REQ;
          end
        end
      end
      default: s_nxt.eng = frcc_pkg::FRCC_ENG_IDLE;
    endcase

    // operation admission by device state
    if (op_valid) begin
      s_nxt.op_done   = 1'b1;
      s_nxt.op_accept = admit(s_r.dev, op_class, op_sector,
                              s_r.susp_sector);
    end

    // apb slave: one wait state, answer on second access cycle
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0;
      case (paddr)
        `FRCC_OFS_CTRL: begin
          if (apb_wr) begin
            s_nxt.dev = frcc_pkg::frcc_dev_type'(
              pwdata[`FRCC_CTRL_DEV_LO +: 2]);
            s_nxt.susp_sector = pwdata[`FRCC_CTRL_SEC_LO +: 16];
          end
          s_nxt.prdata[`FRCC_CTRL_DEV_LO +: 2]  = s_r.dev;
          s_nxt.prdata[`FRCC_CTRL_SEC_LO +: 16] = s_r.susp_sector;
        end
        `FRCC_OFS_FLAG: begin
          // write one clears the range and crc flags; a hardware set this cycle still wins
          if (apb_wr && pwdata[`FRCC_FLAG_RANGE] &&
              !(confirm && bad_range)) begin
            s_nxt.flag_range = 1'b0;
          end
          if (apb_wr && pwdata[`FRCC_FLAG_CRC] &&
              !(last && crc_fold != s_r.exp_crc)) begin
            s_nxt.flag_crc = 1'b0;
          end
          s_nxt.prdata[`FRCC_FLAG_RANGE] = s_r.flag_range;
          s_nxt.prdata[`FRCC_FLAG_SUSP]  = s_r.flag_susp;
          s_nxt.prdata[`FRCC_FLAG_CRC]   = s_r.flag_crc;
          s_nxt.prdata[`FRCC_FLAG_READY] = ~busy;
        end
        `FRCC_OFS_RB_LO: s_nxt.prdata = s_r.rb[31:0];
        `FRCC_OFS_RB_HI: s_nxt.prdata = s_r.rb[63:32];
        `FRCC_OFS_ADDR:  s_nxt.prdata = s_r.addr;
        default:         s_nxt.pslverr = 1'b1;
      endcase
    end

    // software reset aborts the check and clears readback, suspend flag and fetch strobe
    if (soft_rst) begin
      s_nxt.eng       = frcc_pkg::FRCC_ENG_IDLE;
      s_nxt.rb        = `FRCC_RB_RESET;
      s_nxt.flag_susp = 1'b0;
      s_nxt.mem_rd    = 1'b0;
    end
    s_nxt.crc_busy = (s_nxt.eng != frcc_pkg::FRCC_ENG_IDLE);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_r      <= '0;
      s_r.cs_s <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata    = s_r.prdata;
  assign pready    = s_r.pready;
  assign pslverr   = s_r.pslverr;
  assign miso      = s_r.miso;
  assign miso_oe   = s_r.miso_oe;
  assign mem_rd    = s_r.mem_rd;
  assign mem_addr  = s_r.mem_addr;
  assign op_done   = s_r.op_done;
  assign op_accept = s_r.op_accept;
  assign crc_busy  = s_r.crc_busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  range_abort_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    confirm && bad_range && !soft_rst |=>
      s_r.flag_range && s_r.eng == frcc_pkg::FRCC_ENG_IDLE)
    else $error("reversed range not aborted");
  start_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    confirm && !soft_rst |=> s_r.rb == 64'h0)
    else $error("readback not cleared at start");
  fail_store_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    last && crc_fold != s_r.exp_crc && !soft_rst |=>
      s_r.flag_crc && s_r.rb == $past(crc_fold))
    else $error("mismatch not flagged or stored");
  pass_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    last && crc_fold == s_r.exp_crc |=> s_r.rb == 64'h0)
    else $error("passing check left readback nonzero");
  suspend_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    susp_cmd && !last && !soft_rst |=> s_r.flag_susp && busy)
    else $error("suspend flag not set or check stopped");
  suspend_end_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    last |=> !s_r.flag_susp)
    else $error("suspend flag not cleared at end");
  srst_abort_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    soft_rst |=> !busy && s_r.rb == 64'h0 ##1 !s_r.mem_rd)
    else $error("software reset did not abort");
  fetch_order_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_r.eng == frcc_pkg::FRCC_ENG_REQ && !soft_rst |=>
      s_r.mem_rd && s_r.mem_addr == $past(s_r.addr))
    else $error("fetch address wrong");
  suspend_admit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    op_valid && op_class == frcc_pkg::FRCC_OP_SUSPEND &&
      s_r.dev != frcc_pkg::FRCC_DEV_PROG_ERASE |=> op_done && !op_accept)
    else $error("suspend admitted outside busy state");
  nv_admit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    op_valid && (op_class == frcc_pkg::FRCC_OP_WRITE_NV ||
      op_class == frcc_pkg::FRCC_OP_ERASE) |=>
      op_accept == ($past(s_r.dev) == frcc_pkg::FRCC_DEV_STANDBY))
    else $error("erase or nonvolatile write admission wrong");

endmodule

//--- verification/frcc_host.sv
// frcc_host.sv: host end of the serial link, frame and byte tasks
// assumes: the bench calls start, xfer and stop in that order
module frcc_host (
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // deselect time first, so frames never run into each other
  task automatic start;
    #300 cs_n = 1'b0;
    #100;
  endtask
  // msb first out, answer bit taken on the same rising edge
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #62.5 sck = 1'b1;
      r[i] = miso;
      #62.5 sck = 1'b0;
    end
  endtask
  // clock stands still, data line flips once released
  task automatic stop;
    #100 cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

//--- verification/flash_range_crc_check_bench.sv
// flash_range_crc_check_bench.sv: self-checking bench of frcc_top
// assumes: frcc_host compiled first; byte memory modelled here
module flash_range_crc_check_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] crc_poly = 64'h42f0e1eba9ea3693;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, perr;
  logic        sck, cs_n, mosi, miso, miso_oe, mem_rd;
  logic        mem_rvalid = 1'b0;
  logic        pend = 1'b0;
  logic        op_valid, op_done, op_accept, crc_busy;
  logic [2:0]  op_class;
  logic [7:0]  paddr, rb;
  logic [7:0]  mem_rdata = 8'h00;
  logic [15:0] op_sector;
  logic [31:0] pwdata, prdata, mem_addr, rd, s, e;
  logic [63:0] c;
  int          err_total, n_tests, dly;

  frcc_top dut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sck, .cs_n, .mosi, .miso, .miso_oe, .mem_rd,
    .mem_addr, .mem_rdata, .mem_rvalid, .op_valid, .op_class, .op_sector,
    .op_done, .op_accept, .crc_busy);
  frcc_host host (.sck, .cs_n, .mosi, .miso);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // reference models
  // ------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  always @(posedge ref_clk) begin
    mem_rvalid <= 1'b0;
    if (mem_rd) begin
      pend <= 1'b1;
      dly <= $urandom_range(3, 0);
    end else if (pend && dly > 0) dly <= dly - 1;
    else if (pend) begin
      pend <= 1'b0;
      mem_rvalid <= 1'b1;
      mem_rdata <= pat(mem_addr);
    end
  end
  function automatic logic [63:0] crc_of(input logic [31:0] a, b);
    logic [63:0] r;
    logic [7:0] d;
    r = 64'h0;
    for (logic [32:0] i = {1'b0, a}; i <= {1'b0, b}; i++) begin
      d = pat(i[31:0]);
      for (int k = 0; k < 8; k++)
        r = {r[62:0], 1'b0} ^ ((r[63] ^ d[k]) ? crc_poly : 64'h0);
    end
    return r;
  endfunction
  function automatic logic acc(input int d, k, input logic same);
    case (d)
      0: return k != 6;
      1: return k == 1 || k == 6;
      2: return k == 0 || k == 1 || k == 5;
      default: return k == 0 || k == 1 || k == 5 || (k == 2 && !same);
    endcase
  endfunction
  // ------------------------------------------------------------
  // drivers and checks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bail;
    err_total++;
    report_and_stop;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) bail;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hw_reset;
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int k = 0; crc_busy !== lvl; k++) begin
      if (k == 3000) bail;
      @(posedge ref_clk);
    end
  endtask
  task automatic run(input logic [63:0] x, input logic [31:0] a, b);
    logic [151:0] v;
    v = {b, a, x, 24'hfe279b};
    host.start();
    for (int i = 0; i < 19; i++)
      host.xfer(v[8*i+:8], rb);
    host.stop();
  endtask
  task automatic rb_link(input logic [63:0] v);
    host.start();
    host.xfer(8'h96, rb);
    chk(miso_oe, 1'b1);
    for (int i = 0; i < 9; i++) begin
      host.xfer(8'h00, rb);
      chk(rb, i < 8 ? v[8*i+:8] : 8'h00);
    end
    host.stop();
  endtask
  task automatic ask(input int k, input logic [15:0] sec);
    @(posedge ref_clk);
    op_class <= k[2:0];
    op_sector <= sec;
    op_valid <= 1'b1;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    for (int j = 0; op_done !== 1'b1; j++) begin
      if (j == 5) bail;
      @(posedge ref_clk);
    end
  endtask

  initial begin
    {rstn, psel, penable, pwrite, op_valid} = 5'h0;
    {paddr, pwdata, op_class, op_sector} = 59'h0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    void'($urandom(95));
    apb(0, 8'h08, 0);
    chk(rd, 0);
    apb(0, 8'h04, 0);
    chk(rd & 32'h16, 0);
    $display("test reset values done");
    s = $urandom_range(4000, 0);
    c = crc_of(s, s);
    run(c ^ (64'h1 << $urandom_range(63, 0)), s, s);
    wait_busy(1);
    wait_busy(0);
    apb(0, 8'h04, 0);
    chk(rd & 32'h16, 32'h10);
    apb(0, 8'h08, 0);
    chk(rd, c[31:0]);
    apb(0, 8'h0c, 0);
    chk(rd, c[63:32]);
    rb_link(c);
    apb(1, 8'h04, 32'h12);
    $display("test failing check done");
    e = s + $urandom_range(5, 1);
    run(crc_of(s, e), s, e);
    wait_busy(1);
    wait_busy(0);
    apb(0, 8'h04, 0);
    chk(rd & 32'h16, 0);
    rb_link(64'h0);
    apb(0, 8'h10, 0);
    chk(rd, e);
    $display("test passing check done");
    run(0, e, s);
    repeat (40) @(posedge ref_clk);
    chk(crc_busy, 0);
    apb(0, 8'h04, 0);
    chk(rd & 32'h16, 32'h02);
    apb(1, 8'h04, 32'h12);
    $display("test reversed range done");
    run(crc_of(0, 127), 0, 127);
    wait_busy(1);
    host.start();
    host.xfer(8'h75, rb);
    host.stop();
    apb(0, 8'h04, 0);
    chk({crc_busy, rd[2]}, 2'b11);
    wait_busy(0);
    apb(0, 8'h04, 0);
    chk(rd & 32'h16, 0);
    $display("test suspend done");
    run(0, 0, 127);
    wait_busy(1);
    apb(1, 8'h00, 1);
    repeat (800) @(posedge ref_clk);
    apb(0, 8'h04, 0);
    chk({crc_busy, rd[4]}, 0);
    apb(0, 8'h08, 0);
    chk(rd, 0);
    $display("test soft reset done");
    run(0, s, e);
    wait_busy(1);
    wait_busy(0);
    hw_reset;
    apb(0, 8'h08, 0);
    chk(rd, 0);
    run(0, 0, 127);
    wait_busy(1);
    hw_reset;
    apb(0, 8'h04, 0);
    chk({crc_busy, rd & 32'h16}, 0);
    $display("test hardware reset done");
    for (int d = 0; d < 4; d++) begin
      apb(1, 8'h00, {16'h0005, 13'h0, d[1:0], 1'b0});
      for (int k = 0; k < 14; k++) begin
        ask(k / 2, 16'h0005 + k[15:0] % 2);
        chk(op_accept, acc(d, k / 2, k % 2 == 0));
      end
    end
    $display("test admission done");
    apb(0, 8'h20, 0);
    chk({perr, rd}, 33'h100000000);
    $display("test unmapped done");
    report_and_stop;
  end
endmodule
